// file: design/fwg_pkg.sv
// Constants, types and carriers of the flash write and erase guard.
// Assumes a single 125 MHz clock shared by core, bus and flash macro.
package fwg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and codes
  localparam logic [7:0] FWG_UNLOCK_ADDR = 8'hb7;
  localparam logic [7:0] FWG_UNLOCK_RST = 8'h00;
  localparam logic [7:0] FWG_KEY_FIRST = 8'ha5;
  localparam logic [7:0] FWG_KEY_SECOND = 8'hf1;
  localparam logic [7:0] FWG_ERASED_BYTE = 8'hff;
  localparam int FWG_STAT_LSB = 0;
  localparam int FWG_STAT_W = 2;
  localparam logic [1:0] FWG_STAT_LOCKED = 2'h0;
  localparam logic [1:0] FWG_STAT_KEY1 = 2'h1;
  localparam logic [1:0] FWG_STAT_OPEN = 2'h2;
  localparam logic [1:0] FWG_STAT_DEAD = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Flash geometry
  localparam int FWG_ADDR_W = 16;
  localparam int FWG_PAGE_LSB = 9;
  localparam int FWG_PAGE_BYTES = 512;
  localparam logic [15:0] FWG_ADDR8_LIMIT = 16'h00ff;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int FWG_CLK_PERIOD_NS = 8;
  localparam int FWG_PROG_TIME_US = 40;
  localparam int FWG_ERASE_TIME_US = 20000;
  localparam int FWG_PROG_CYCLES =
    (FWG_PROG_TIME_US * 1000 + FWG_CLK_PERIOD_NS - 1) / FWG_CLK_PERIOD_NS;
  localparam int FWG_ERASE_CYCLES =
    (FWG_ERASE_TIME_US * 1000 + FWG_CLK_PERIOD_NS - 1) / FWG_CLK_PERIOD_NS;
  localparam int FWG_CNT_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // States and carriers
  typedef enum logic [1:0] {
    FWG_LK_LOCKED = 2'h0,
    FWG_LK_KEY1 = 2'h1,
    FWG_LK_OPEN = 2'h3,
    FWG_LK_DEAD = 2'h2
  } fwg_lock_type;

  typedef enum logic [1:0] {
    FWG_OP_IDLE = 2'h0,
    FWG_OP_FETCH = 2'h1,
    FWG_OP_BUSY = 2'h3
  } fwg_op_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic addr8;
  } fwg_xwr_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fwg_sfr_type;

endpackage

// file: design/fwg_guard.sv
// Flash write and erase guard: unlock key register, op timing, core stall.
// Assumes a special-register port on ref_clk, one core write per pulse,
// and a flash macro with a combinational read port on flash_addr.
//
// Function
// RQ1 - Flash is programmed one byte at a time
// RQ2 - Programming only clears bits, never sets
// RQ3 - Program and erase timed internally, no polling
// RQ4 - Core stalled for whole program or erase
// RQ5 - Two keys in order unlock one operation
// RQ6 - Wrong or misordered key disables until reset
// RQ7 - Attempt before unlock disables until reset
// RQ8 - Relock after every completed operation
// RQ9 - Write enable steers core writes to flash
// RQ10 - Erase sets whole fixed page to erased
// RQ11 - Erase select plus enable erases page
// RQ12 - Short-address writes above limit cannot touch flash
// RQ13 - Software sets timing bit before operations
// RQ14 - Non-first-key initial write locks flash
// RQ15 - Unlock register reads lock state low bits
// RQ16 - Software clears enable bits after erase
// RQ17 - Reads by code move, writes redirected
// RQ18 - Refused attempt leaves flash, core untouched
// RQ19 - Enable clear sends writes to data memory
module fwg_guard
  import fwg_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = FWG_PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = FWG_ERASE_CYCLES
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire fwg_sfr_type sfr_bus, // Special register access
  output logic [7:0] sfr_rdata, // Register read data
  input wire logic core_wr_valid, // Core write pulse
  input wire fwg_xwr_type core_wr, // Core write address and data
  output logic core_stall, // Holds the core
  input wire logic store_write_enable, // Writes go to flash
  input wire logic store_erase_select, // Flash writes erase
  input wire logic flash_write_timing_bit, // Timing control, passed on
  output logic xram_we, // Data memory write pulse
  output logic [15:0] xram_addr, // Data memory address
  output logic [7:0] xram_wdata, // Data memory data
  input wire logic [7:0] flash_rdata, // Byte at flash_addr
  output logic flash_prog, // Byte program active
  output logic flash_erase, // Page erase active
  output logic flash_timing, // Timing control to macro
  output logic [15:0] flash_addr, // Byte or page address
  output logic [7:0] flash_wdata, // Byte to program
  output logic [1:0] lock_state // Current lock state code
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  fwg_lock_type lock_r, lock_nxt;
  fwg_op_type op_r, op_nxt;
  logic [FWG_CNT_W-1:0] cnt_r, cnt_nxt;
  logic erase_r, erase_nxt;
  logic [15:0] faddr_r, faddr_nxt;
  logic [7:0] fdata_r, fdata_nxt;
  logic prog_r, prog_nxt;
  logic ers_r, ers_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic xwe_r, xwe_nxt;
  logic [15:0] xaddr_r, xaddr_nxt;
  logic [7:0] xdata_r, xdata_nxt;

  function automatic logic [1:0] stat_code(input fwg_lock_type s);
    unique case (s)
      FWG_LK_LOCKED: stat_code = FWG_STAT_LOCKED;
      FWG_LK_KEY1: stat_code = FWG_STAT_KEY1;
      FWG_LK_OPEN: stat_code = FWG_STAT_OPEN;
      FWG_LK_DEAD: stat_code = FWG_STAT_DEAD;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic key_wr;
  logic key_rd;
  logic to_flash;
  logic addr_ok;
  logic attempt;

  always_comb begin
    key_wr = sfr_bus.wr && (sfr_bus.addr == FWG_UNLOCK_ADDR);
    key_rd = sfr_bus.rd && (sfr_bus.addr == FWG_UNLOCK_ADDR);
    to_flash = core_wr_valid && store_write_enable; // RQ9 RQ17
    addr_ok = !(core_wr.addr8 && (core_wr.addr > FWG_ADDR8_LIMIT)); // RQ12
    attempt = to_flash && addr_ok && (op_r == FWG_OP_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock and key

  always_comb begin
    lock_nxt = lock_r;
    if (key_wr) begin
      unique case (lock_r)
        FWG_LK_LOCKED: begin
          if (sfr_bus.wdata == FWG_KEY_FIRST) begin
            lock_nxt = FWG_LK_KEY1; // RQ5
          end else begin
            lock_nxt = FWG_LK_DEAD; // RQ6 RQ14
          end
        end
        FWG_LK_KEY1: begin
          if (sfr_bus.wdata == FWG_KEY_SECOND) begin
            lock_nxt = FWG_LK_OPEN; // RQ5
          end else begin
            lock_nxt = FWG_LK_DEAD; // RQ6
          end
        end
        FWG_LK_OPEN: lock_nxt = FWG_LK_DEAD; // RQ6
        FWG_LK_DEAD: lock_nxt = FWG_LK_DEAD;
      endcase
    end
    // Refused attempt disables; dead state always wins
    if (attempt && (lock_r != FWG_LK_OPEN)) begin
      lock_nxt = FWG_LK_DEAD; // RQ7
    end
    if ((op_r == FWG_OP_BUSY) && (cnt_r == '0) &&
        (lock_nxt != FWG_LK_DEAD)) begin
      lock_nxt = FWG_LK_LOCKED; // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation sequencer

  always_comb begin
    op_nxt = op_r;
    cnt_nxt = cnt_r;
    erase_nxt = erase_r;
    faddr_nxt = faddr_r;
    fdata_nxt = fdata_r;
    prog_nxt = 1'b0;
    ers_nxt = 1'b0;
    unique case (op_r)
      FWG_OP_IDLE: begin
        if (attempt && (lock_r == FWG_LK_OPEN)) begin
          erase_nxt = store_erase_select; // RQ11
          fdata_nxt = core_wr.data;
          if (store_erase_select) begin
            // Page aligned, whole page goes to the erased value
            faddr_nxt = {core_wr.addr[15:FWG_PAGE_LSB],
                         {FWG_PAGE_LSB{1'b0}}}; // RQ10
            cnt_nxt = FWG_CNT_W'(ERASE_CYCLES - 1); // RQ3
            ers_nxt = 1'b1;
            op_nxt = FWG_OP_BUSY;
          end else begin
            faddr_nxt = core_wr.addr; // RQ1
            op_nxt = FWG_OP_FETCH;
          end
        end
      end
      FWG_OP_FETCH: begin
        // Merge with stored byte so that no bit can rise
        fdata_nxt = fdata_r & flash_rdata; // RQ2
        cnt_nxt = FWG_CNT_W'(PROG_CYCLES - 1); // RQ3
        prog_nxt = 1'b1;
        op_nxt = FWG_OP_BUSY;
      end
      FWG_OP_BUSY: begin
        if (cnt_r == '0) begin
          op_nxt = FWG_OP_IDLE; // RQ3
        end else begin
          cnt_nxt = cnt_r - 1'b1;
          prog_nxt = !erase_r;
          ers_nxt = erase_r;
        end
      end
      default: op_nxt = FWG_OP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory path and register read

  always_comb begin
    xwe_nxt = core_wr_valid && !store_write_enable; // RQ19
    xaddr_nxt = xaddr_r;
    xdata_nxt = xdata_r;
    if (xwe_nxt) begin
      xaddr_nxt = core_wr.addr;
      xdata_nxt = core_wr.data;
    end
    rdata_nxt = 8'h00;
    if (key_rd) begin
      rdata_nxt[FWG_STAT_LSB +: FWG_STAT_W] = stat_code(lock_r); // RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_r <= FWG_LK_LOCKED;
      op_r <= FWG_OP_IDLE;
      cnt_r <= '0;
      erase_r <= 1'b0;
      faddr_r <= '0;
      fdata_r <= FWG_ERASED_BYTE;
      prog_r <= 1'b0;
      ers_r <= 1'b0;
      rdata_r <= FWG_UNLOCK_RST;
      xwe_r <= 1'b0;
      xaddr_r <= '0;
      xdata_r <= '0;
    end else begin
      lock_r <= lock_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
      erase_r <= erase_nxt;
      faddr_r <= faddr_nxt;
      fdata_r <= fdata_nxt;
      prog_r <= prog_nxt;
      ers_r <= ers_nxt;
      rdata_r <= rdata_nxt;
      xwe_r <= xwe_nxt;
      xaddr_r <= xaddr_nxt;
      xdata_r <= xdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Refused attempts never leave idle, so they never stall
  assign core_stall = (op_r != FWG_OP_IDLE); // RQ4 RQ18
  assign sfr_rdata = rdata_r;
  assign xram_we = xwe_r;
  assign xram_addr = xaddr_r;
  assign xram_wdata = xdata_r;
  assign flash_prog = prog_r;
  assign flash_erase = ers_r;
  assign flash_timing = flash_write_timing_bit;
  assign flash_addr = faddr_r;
  assign flash_wdata = fdata_r;
  assign lock_state = stat_code(lock_r);

endmodule

// file: sim/fwg_guard_assertions.sv
// Checker for the flash guard: key steps, lockout, op timing.
// Assumes binding to fwg_guard, one clock, rst high.
module fwg_guard_assertions
  import fwg_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire fwg_sfr_type sfr_bus, // Register port
  input wire logic core_wr_valid, // Core write
  input wire fwg_xwr_type core_wr, // Write fields
  input wire logic core_stall, // Stall
  input wire logic store_write_enable, // To flash
  input wire logic store_erase_select, // Erase
  input wire logic flash_prog, // Program
  input wire logic flash_erase, // Erase level
  input wire logic [15:0] flash_addr, // Address
  input wire logic [7:0] flash_wdata, // New byte
  input wire logic [7:0] flash_rdata, // Old byte
  input wire logic [1:0] lock_state // Lock code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic kw, lng, req;
  assign kw = sfr_bus.wr && sfr_bus.addr == FWG_UNLOCK_ADDR;
  assign lng = core_wr.addr8 && core_wr.addr > FWG_ADDR8_LIMIT;
  assign req = core_wr_valid && store_write_enable && !lng;
  property p_key1; kw && !req && lock_state == 2'h0 |=> lock_state ==
    ($past(sfr_bus.wdata) == FWG_KEY_FIRST ? 2'h1 : 2'h3); endproperty
  a_key1: assert property (p_key1) else $error("first key");
  property p_key2; kw && !req && lock_state == 2'h1 |=> lock_state ==
    ($past(sfr_bus.wdata) == FWG_KEY_SECOND ? 2'h2 : 2'h3); endproperty
  a_key2: assert property (p_key2) else $error("second key");
  property p_dead; lock_state == 2'h3 |=> lock_state == 2'h3; endproperty
  a_dead: assert property (p_dead) else $error("dead left");
  property p_refuse; req && !core_stall && lock_state != 2'h2
    |=> !core_stall && lock_state == 2'h3; endproperty
  a_refuse: assert property (p_refuse) else $error("refuse");
  property p_prog; req && !kw && !core_stall && lock_state == 2'h2 &&
    !store_erase_select |=> core_stall && !flash_prog ##1 flash_prog;
  endproperty
  a_prog: assert property (p_prog) else $error("prog start");
  property p_erase; req && !kw && !core_stall && lock_state == 2'h2 &&
    store_erase_select |=> flash_erase && flash_addr[8:0] == 9'h0;
  endproperty
  a_erase: assert property (p_erase) else $error("erase start");
  property p_relock; $fell(core_stall) |-> lock_state == 2'h0; endproperty
  a_relock: assert property (p_relock) else $error("relock");
  property p_and;
    $rose(flash_prog) |-> (flash_wdata & ~$past(flash_rdata)) == 8'h00;
  endproperty
  a_and: assert property (p_and) else $error("bit set");
  property p_rekey; kw && lock_state == 2'h2 |=> lock_state == 2'h3;
  endproperty
  a_rekey: assert property (p_rekey) else $error("key when open");
  c_prog: cover property ($rose(flash_prog));
  c_erase: cover property ($rose(flash_erase));
  c_dead: cover property (lock_state == 2'h3);
endmodule

bind fwg_guard fwg_guard_assertions i_fwg_guard_assertions (
  .ref_clk(ref_clk), .rst(rst), .sfr_bus(sfr_bus),
  .core_wr_valid(core_wr_valid), .core_wr(core_wr), .core_stall(core_stall),
  .store_write_enable(store_write_enable),
  .store_erase_select(store_erase_select), .flash_prog(flash_prog),
  .flash_erase(flash_erase), .flash_addr(flash_addr),
  .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
  .lock_state(lock_state));

// file: sim/fwg_flash_model.sv
// Flash array model: byte program clears bits, erase fills a page.
// Assumes test addresses below 0x0400.
module fwg_flash_model
  import fwg_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic flash_prog, // Program
  input wire logic flash_erase, // Erase
  input wire logic [15:0] flash_addr, // Address
  input wire logic [7:0] flash_wdata, // New byte
  output logic [7:0] flash_rdata // Byte read
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:1023];
  initial for (int i = 0; i < 1024; i++) mem[i] = FWG_ERASED_BYTE;
  assign flash_rdata = mem[flash_addr[9:0]];
  always @(posedge ref_clk) begin
    if (flash_prog)
      mem[flash_addr[9:0]] <= mem[flash_addr[9:0]] & flash_wdata;
    if (flash_erase)
      for (int i = 0; i < FWG_PAGE_BYTES; i++)
        mem[{flash_addr[9], i[8:0]}] <= FWG_ERASED_BYTE;
  end
endmodule

// file: sim/tb_fwg_guard.sv
// Bench for the flash guard: keys, program, erase, lockouts.
// Assumes the flash model answers reads combinationally.
module tb_fwg_guard
  import fwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC = 4;
  localparam int EC = 8;
  logic ref_clk = 0, rst = 1, core_wr_valid = 0, xram_we, core_stall;
  logic store_write_enable = 0, store_erase_select = 0, flash_prog;
  logic flash_erase, flash_timing, flash_write_timing_bit = 0;
  logic [7:0] sfr_rdata, flash_rdata, flash_wdata, xram_wdata;
  logic [15:0] xram_addr, flash_addr;
  logic [1:0] lock_state;
  fwg_sfr_type sfr_bus = '0;
  fwg_xwr_type core_wr = '0;
  int err_count = 0, total_checks = 0, cyc = 0;
  fwg_guard #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_fwg_guard (
    .ref_clk(ref_clk), .rst(rst), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata),
    .core_wr_valid(core_wr_valid), .core_wr(core_wr), .core_stall(core_stall),
    .store_write_enable(store_write_enable), .flash_timing(flash_timing),
    .store_erase_select(store_erase_select),
    .flash_write_timing_bit(flash_write_timing_bit),
    .xram_we(xram_we), .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .flash_rdata(flash_rdata), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .lock_state(lock_state));
  fwg_flash_model i_fwg_flash_model (.ref_clk(ref_clk),
    .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata));
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  task automatic results;
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reset(int n);
    rst = 1;
    repeat (n) @(negedge ref_clk);
    rst = 0;
  endtask
  task automatic kw(logic [7:0] d);
    sfr_bus = '{FWG_UNLOCK_ADDR, d, 1'b1, 1'b0};
    @(negedge ref_clk) sfr_bus = '0;
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [1:0] e);
    sfr_bus = '{FWG_UNLOCK_ADDR, 8'h00, 1'b0, 1'b1};
    @(negedge ref_clk) sfr_bus = '0;
    chk("lock read", {14'h0, e}, {8'h0, sfr_rdata});
    @(negedge ref_clk);
  endtask
  task automatic unlock;
    kw(FWG_KEY_FIRST);
    kw(FWG_KEY_SECOND);
  endtask
  task automatic op(logic [15:0] a, logic [7:0] d, logic a8, int ns);
    int n;
    n = 0;
    core_wr = '{a, d, a8};
    core_wr_valid = 1;
    @(negedge ref_clk) core_wr_valid = 0;
    while (core_stall === 1'b1 && n < 50) begin
      n++;
      @(negedge ref_clk);
    end
    chk("stall cycles", ns[15:0], n[15:0]);
  endtask
  function automatic logic [15:0] fb(int a);
    return {8'h0, i_fwg_flash_model.mem[a]};
  endfunction
  task automatic s_data_path;
    rd(2'h0);
    op(16'h0105, 8'h5a, 0, 0);
    chk("xram we", 16'h1, {15'h0, xram_we});
    chk("xram addr", 16'h0105, xram_addr);
    chk("xram data", 16'h005a, {8'h0, xram_wdata});
    chk("timing low", 16'h0, {15'h0, flash_timing});
    chk("flash byte", 16'hff, fb(16'h0105));
  endtask
  task automatic s_program;
    flash_write_timing_bit = 1;
    kw(FWG_KEY_FIRST);
    rd(2'h1);
    chk("timing high", 16'h1, {15'h0, flash_timing});
    kw(FWG_KEY_SECOND);
    rd(2'h2);
    store_write_enable = 1;
    op(16'h0105, 8'h3c, 0, PC + 1);
    rd(2'h0);
    chk("programmed", 16'h3c, fb(16'h0105));
    unlock();
    op(16'h0105, 8'hf0, 0, PC + 1);
    chk("cleared only", 16'h30, fb(16'h0105));
    chk("neighbour", 16'hff, fb(16'h0106));
  endtask
  task automatic s_addr8_erase;
    unlock();
    op(16'h0180, 8'h00, 1, 0);
    rd(2'h2);
    op(16'h0010, 8'h0f, 1, PC + 1);
    chk("short form", 16'h0f, fb(16'h0010));
    unlock();
    store_erase_select = 1;
    op(16'h01ee, 8'h00, 0, EC);
    chk("erased", 16'hff, fb(16'h0105));
    chk("erased low", 16'hff, fb(16'h0010));
    rd(2'h0);
    store_write_enable = 0;
    store_erase_select = 0;
  endtask
  task automatic s_lockouts;
    store_write_enable = 1;
    op(16'h0106, 8'h00, 0, 0);
    rd(2'h3);
    chk("untouched", 16'hff, fb(16'h0106));
    unlock();
    rd(2'h3);
    reset(2);
    kw(FWG_KEY_FIRST);
    op(16'h0106, 8'h00, 0, 0);
    rd(2'h3);
    reset(2);
    kw(FWG_KEY_FIRST);
    kw(8'h00);
    rd(2'h3);
    reset(2);
    kw(8'h12);
    rd(2'h3);
    reset(2);
    unlock();
    kw(FWG_KEY_FIRST);
    rd(2'h3);
  endtask
  initial begin
    reset(16);
    s_data_path();
    s_program();
    s_addr8_erase();
    s_lockouts();
    results();
  end
endmodule
